// ===== rtl/wldc_pkg.sv
// Package with the offsets, field positions, reset values and timing of the wake/LED config block.
package wldc_pkg;
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned DATA_W       = 8;
  // Register offsets.
  localparam logic [7:0]  OFF_EE_CMD   = 8'h50;
  localparam logic [7:0]  OFF_WLDC_CFG = 8'h52;
  localparam logic [7:0]  OFF_WPAT_CFG = 8'h55;
  // Field positions.
  localparam int unsigned EEM_HI       = 7;
  localparam int unsigned EEM_LO       = 6;
  localparam int unsigned LED_HI       = 7;
  localparam int unsigned LED_LO       = 6;
  localparam int unsigned DRV_BIT      = 5;
  localparam int unsigned WACT_BIT     = 4;
  localparam int unsigned MMAP_BIT     = 3;
  localparam int unsigned WPTN_BIT     = 0;
  // Reset values and mode codes.
  localparam logic [1:0]  LED_RST      = 2'h0;
  localparam logic        DRV_RST      = 1'b0;
  localparam logic        WACT_RST     = 1'b0;
  localparam logic        WPTN_RST     = 1'b0;
  localparam logic [1:0]  EEM_NORMAL   = 2'h0;
  localparam logic [1:0]  EEM_AUTOLOAD = 2'h1;
  // Timing.
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned AUTOLOAD_US  = 2000;
  localparam int unsigned PULSE_MS     = 150;
  localparam int unsigned AUTOLOAD_CYC = AUTOLOAD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned PULSE_CYC    = PULSE_MS * (CLK_HZ / 1000);
  // Load sequencer states.
  typedef enum logic [1:0] {
    WLDC_ST_START,
    WLDC_ST_WAIT,
    WLDC_ST_IDLE
  } wldc_state_e;
endpackage

// ===== rtl/wldc_tmr_if.sv
// Interface between the config block and one of its interval timers.
`timescale 1ns/1ps
`default_nettype none
interface wldc_tmr_if;
  logic start;
  logic busy;
  logic done;
  modport ctl (output start, input busy, input done);
  modport tmr (input start, output busy, output done);
endinterface
`default_nettype wire

// ===== rtl/wldc_pulse_timer.sv
// Down counter that stays busy for COUNT cycles after a start and flags its last cycle.
`timescale 1ns/1ps
`default_nettype none
module wldc_pulse_timer
  import wldc_pkg::*;
#(
  parameter int unsigned COUNT = 4
) (
  input  wire logic   clk,
  input  wire logic   rst,
  wldc_tmr_if.tmr     tmr
);
  localparam int unsigned CNT_W = $clog2(COUNT + 1);

  logic [CNT_W-1:0] cnt_q;

  // A start while busy reloads, so a new event stretches the interval.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (tmr.start) begin
      cnt_q <= CNT_W'(COUNT);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - CNT_W'(1);
    end
  end

  // Busy is decoded straight from the count; done from a count of one with no start in the same cycle.
  assign tmr.busy = (cnt_q != '0);
  assign tmr.done = (cnt_q == CNT_W'(1)) && !tmr.start;
endmodule
`default_nettype wire

// ===== rtl/wldc_top.sv
// Wake and LED configuration register with auto-load sequencing and wake pin shaping.
`timescale 1ns/1ps
`default_nettype none
module wldc_top
  import wldc_pkg::*;
#(
  parameter int unsigned LOAD_CYCLES  = AUTOLOAD_CYC,
  parameter int unsigned PULSE_CYCLES = PULSE_CYC
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  input  wire logic              pci_cmd_en_wr,
  input  wire logic [1:0]        eeprom_led_mode,
  input  wire logic              wake_event,
  input  wire logic              cardbus_mode_pin,
  input  wire logic              memory_space_mapped_pin,
  output logic                   wake_output_pin,
  output logic      [1:0]        led_mode_select,
  output logic                   load_busy
);
  wldc_tmr_if load_if ();
  wldc_tmr_if pulse_if ();

  wldc_state_e state_q;
  logic [1:0]  eem_q;
  logic [1:0]  led_q;
  logic        drv_q;
  logic        wact_q;
  logic        wptn_q;
  logic [1:0]  cb_sync_q;
  logic [1:0]  mmap_sync_q;
  logic        wake_prev_q;
  logic        wake_q;
  logic        wr_cfg;
  logic        wr_ee;
  logic        wr_pat;
  logic        load_end;
  logic        act_eff;
  logic        ptn_eff;
  logic        wake_rise;
  logic        wake_d;
  logic [DATA_W-1:0] rdata_d;

  // Address decode of the write strobe.
  assign wr_cfg   = reg_wr && (reg_addr == OFF_WLDC_CFG);
  assign wr_ee    = reg_wr && (reg_addr == OFF_EE_CMD);
  assign wr_pat   = reg_wr && (reg_addr == OFF_WPAT_CFG);
  assign load_end = (state_q == WLDC_ST_WAIT) && load_if.done;

  wldc_pulse_timer #(
    .COUNT (LOAD_CYCLES)
  ) u_load_timer (
    .clk (clk),
    .rst (rst),
    .tmr (load_if.tmr)
  );

  wldc_pulse_timer #(
    .COUNT (PULSE_CYCLES)
  ) u_pulse_timer (
    .clk (clk),
    .rst (rst),
    .tmr (pulse_if.tmr)
  );

  // Straps from pins pass two flops; only the second stage is read.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cb_sync_q   <= 2'h0;
      mmap_sync_q <= 2'h0;
    end else begin
      cb_sync_q   <= {cb_sync_q[0], cardbus_mode_pin};
      mmap_sync_q <= {mmap_sync_q[0], memory_space_mapped_pin};
    end
  end

  // Load sequencer: a reset always runs one EEPROM load, since the LED field
  // cannot take a port value under the asynchronous reset itself.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= WLDC_ST_START;
      eem_q   <= EEM_AUTOLOAD;
    end else begin
      case (state_q)
        WLDC_ST_START: begin
          state_q <= WLDC_ST_WAIT;
        end
        WLDC_ST_WAIT: begin
          if (load_if.done) begin
            state_q <= WLDC_ST_IDLE;
            eem_q   <= EEM_NORMAL;
          end
        end
        WLDC_ST_IDLE: begin
          if (wr_ee) begin
            eem_q <= reg_wdata[EEM_HI:EEM_LO];
            if (reg_wdata[EEM_HI:EEM_LO] == EEM_AUTOLOAD) begin
              state_q <= WLDC_ST_START;
            end
          end
        end
        default: begin
          state_q <= WLDC_ST_IDLE;
        end
      endcase
    end
  end

  assign load_if.start = (state_q == WLDC_ST_START);
  assign load_busy     = (state_q != WLDC_ST_IDLE);

  // LED mode: software writable, overwritten by each completed load.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      led_q <= LED_RST;
    end else if (load_end) begin
      led_q <= eeprom_led_mode;
    end else if (wr_cfg) begin
      led_q <= reg_wdata[LED_HI:LED_LO];
    end
  end

  // Driver flag: a software write in the same cycle as a command-enable write
  // wins, since it is the later intent of the driver.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drv_q <= DRV_RST;
    end else if (wr_cfg) begin
      drv_q <= reg_wdata[DRV_BIT];
    end else if (pci_cmd_en_wr || load_end) begin
      drv_q <= DRV_RST;
    end
  end

  // Wake shape bits; a completed load restores their defaults as well.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wact_q <= WACT_RST;
      wptn_q <= WPTN_RST;
    end else if (load_end) begin
      wact_q <= WACT_RST;
      wptn_q <= WPTN_RST;
    end else begin
      if (wr_cfg) begin
        wact_q <= reg_wdata[WACT_BIT];
      end
      if (wr_pat) begin
        wptn_q <= reg_wdata[WPTN_BIT];
      end
    end
  end

  // In CardBus operation the shape falls back to an active-high level.
  assign act_eff   = wact_q && !cb_sync_q[1];
  assign ptn_eff   = wptn_q && !cb_sync_q[1];
  assign wake_rise = wake_event && !wake_prev_q;
  assign pulse_if.start = wake_rise && ptn_eff;

  // Wake pin: level forms follow the event, pulse forms follow the timer.
  always_comb begin
    if (ptn_eff) begin
      wake_d = pulse_if.busy ^ act_eff;
    end else begin
      wake_d = wake_event ^ act_eff;
    end
  end

  // Pin register; idles low at reset, matching the default active-high form.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_prev_q <= 1'b0;
      wake_q      <= 1'b0;
    end else begin
      wake_prev_q <= wake_event;
      wake_q      <= wake_d;
    end
  end

  assign wake_output_pin = wake_q;
  assign led_mode_select = led_q;

  // Read mux; unmapped addresses and reserved bits read as zero.
  always_comb begin
    rdata_d = 8'h00;
    case (reg_addr)
      OFF_EE_CMD: begin
        rdata_d[EEM_HI:EEM_LO] = eem_q;
      end
      OFF_WLDC_CFG: begin
        rdata_d[LED_HI:LED_LO] = led_q;
        rdata_d[DRV_BIT]       = drv_q;
        rdata_d[WACT_BIT]      = wact_q;
        rdata_d[MMAP_BIT]      = mmap_sync_q[1];
      end
      OFF_WPAT_CFG: begin
        rdata_d[WPTN_BIT] = wptn_q;
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  a_led_write: assert property (@(posedge clk) disable iff (rst)
    wr_cfg && !load_end |=> led_q == $past(reg_wdata[LED_HI:LED_LO]))
    else $error("LED mode did not take the written value");

  a_drv_write: assert property (@(posedge clk) disable iff (rst)
    wr_cfg ##1 (reg_rd && reg_addr == OFF_WLDC_CFG)
      |=> reg_rdata[DRV_BIT] == $past(reg_wdata[DRV_BIT], 2))
    else $error("Driver flag did not read back the written value");

  a_drv_clear: assert property (@(posedge clk) disable iff (rst)
    pci_cmd_en_wr && !wr_cfg |=> !drv_q)
    else $error("Driver flag not cleared by command enable write");

  a_wake_level: assert property (@(posedge clk) disable iff (rst)
    !ptn_eff |=> wake_output_pin == ($past(wake_event) ^ $past(act_eff)))
    else $error("Wake level form wrong for the selected polarity");

  a_pulse_hold: assert property (@(posedge clk) disable iff (rst)
    pulse_if.start && ptn_eff ##1 ptn_eff |=> (wake_output_pin != act_eff))
    else $error("Wake pulse did not start after the event");

  a_pulse_len: assert property (@(posedge clk) disable iff (rst)
    $rose(pulse_if.busy) |-> pulse_if.busy [*8])
    else $error("Wake pulse shorter than expected");

  a_reset_shape: assert property (@(posedge clk) disable iff (rst)
    $past(rst) |-> !wact_q && !wptn_q)
    else $error("Wake shape bits not zero after reset");

  a_cardbus_lvl: assert property (@(posedge clk) disable iff (rst)
    cb_sync_q[1] |=> wake_output_pin == $past(wake_event))
    else $error("Wake shape bits acted in CardBus operation");

  a_mmap_ro: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == OFF_WLDC_CFG |=> reg_rdata[MMAP_BIT] == $past(mmap_sync_q[1]))
    else $error("Memory-mapped status bit does not follow its strap");

  a_load_return: assert property (@(posedge clk) disable iff (rst)
    load_end |=> eem_q == EEM_NORMAL && led_q == $past(eeprom_led_mode)
      && state_q == WLDC_ST_IDLE)
    else $error("Auto-load did not reload and return to normal mode");

  a_load_timer: assert property (@(posedge clk) disable iff (rst)
    state_q == WLDC_ST_WAIT |-> load_if.busy)
    else $error("Load timer idle while the load still waits on it");

  a_pulse_end: assert property (@(posedge clk) disable iff (rst)
    pulse_if.done && ptn_eff |=> !pulse_if.busy && wake_output_pin != $past(act_eff))
    else $error("Wake pulse did not run through its last cycle");
endmodule
`default_nettype wire

// ===== tb/wldc_host_model.sv
// Host-side model that turns a command-register write request into the enable-write pulse.
`timescale 1ns/1ps
`default_nettype none
module wldc_host_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic cmd_req,
  output logic      pci_cmd_en_wr
);
  // One pulse per request cycle, a cycle late, as a config write decode would give it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pci_cmd_en_wr <= 1'b0;
    end else begin
      pci_cmd_en_wr <= cmd_req;
    end
  end
endmodule
`default_nettype wire

// ===== tb/wake_led_driver_config_reg_tb.sv
// Self-checking testbench for the wake and LED configuration register block.
`timescale 1ns/1ps
`default_nettype none
module wake_led_driver_config_reg_tb
  import wldc_pkg::*;
;
  localparam int unsigned LOADC  = 10;
  localparam int unsigned PULSEC = 12;
  logic       clk, rst, wr, rd, cmd_req, en_wr, wake_ev, cbus, mmap, wake_pin, busy;
  logic [7:0] addr, wdata, rdata;
  logic [1:0] ee_led, led;
  int         bad_count, n_compared, cyc, n;

  wldc_host_model host (.clk(clk), .rst(rst), .cmd_req(cmd_req), .pci_cmd_en_wr(en_wr));

  wldc_top #(.LOAD_CYCLES(LOADC), .PULSE_CYCLES(PULSEC)) uut (
    .clk(clk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .pci_cmd_en_wr(en_wr), .eeprom_led_mode(ee_led), .wake_event(wake_ev),
    .cardbus_mode_pin(cbus), .memory_space_mapped_pin(mmap), .wake_output_pin(wake_pin),
    .led_mode_select(led), .load_busy(busy));

  // Clock at 10 MHz.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // A hang counts as a mismatch and closes the run.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, so it is sampled just there.
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp, what);
  endtask

  // Write, then read back in the very next cycle with no gap between the strobes.
  task automatic wrchk(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp,
                       input string what);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp, what);
  endtask

  task automatic wait_idle;
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 100) begin
      @(posedge clk);
      #1 k++;
    end
    chk({7'h00, busy}, 8'h00, "load end");
  endtask

  task automatic pin_after(input int c, input logic exp, input string what);
    repeat (c) @(posedge clk);
    #1 chk({7'h00, wake_pin}, {7'h00, exp}, what);
  endtask

  // Raises the wake request and counts the cycles the pin spends at lvl.
  task automatic pulse_len(input logic lvl);
    @(posedge clk);
    wake_ev <= 1'b1;
    n = 0;
    repeat (30) begin
      @(posedge clk);
      #1 if (wake_pin === lvl) n++;
    end
    @(posedge clk);
    wake_ev <= 1'b0;
  endtask

  initial begin
    rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 8'h00; cmd_req = 1'b0;
    wake_ev = 1'b0; cbus = 1'b0; mmap = 1'b1; ee_led = 2'h2; cyc = 0;
    bad_count = 0; n_compared = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    wait_idle();
    chk({6'h00, led}, 8'h02, "led after load");
    rchk(OFF_WLDC_CFG, 8'h88, "cfg reset");
    rchk(OFF_WPAT_CFG, 8'h00, "pulse sel reset");
    wr8(OFF_WLDC_CFG, 8'hF0);
    rchk(OFF_WLDC_CFG, 8'hF8, "write ones");
    wr8(OFF_WLDC_CFG, 8'h07);
    rchk(OFF_WLDC_CFG, 8'h08, "write zeros, status kept");
    chk({6'h00, led}, 8'h00, "led output");
    // The strap goes through a two-flop sync, so give it a few cycles.
    @(posedge clk);
    mmap <= 1'b0;
    repeat (3) @(posedge clk);
    rchk(OFF_WLDC_CFG, 8'h00, "status follows strap");
    wrchk(OFF_WLDC_CFG, 8'h20, 8'h20, "flag set");
    @(posedge clk);
    cmd_req <= 1'b1;
    @(posedge clk);
    cmd_req <= 1'b0;
    repeat (2) @(posedge clk);
    rchk(OFF_WLDC_CFG, 8'h00, "flag cleared");
    // Level forms: active high, then active low.
    wr8(OFF_WLDC_CFG, 8'h00);
    wake_ev <= 1'b1;
    pin_after(3, 1'b1, "active high on");
    wake_ev <= 1'b0;
    pin_after(3, 1'b0, "active high off");
    wr8(OFF_WLDC_CFG, 8'h10);
    pin_after(3, 1'b1, "active low idle");
    wake_ev <= 1'b1;
    pin_after(3, 1'b0, "active low on");
    wake_ev <= 1'b0;
    // Pulse forms: positive, then negative.
    wr8(OFF_WPAT_CFG, 8'h01);
    wr8(OFF_WLDC_CFG, 8'h00);
    pin_after(3, 1'b0, "pulse idle");
    pulse_len(1'b1);
    chk(n[7:0], PULSEC[7:0], "positive pulse width");
    wr8(OFF_WLDC_CFG, 8'h10);
    pin_after(3, 1'b1, "neg pulse idle");
    pulse_len(1'b0);
    chk(n[7:0], PULSEC[7:0], "negative pulse width");
    // CardBus forces the plain active-high level.
    cbus <= 1'b1;
    pin_after(4, 1'b0, "cardbus idle");
    wake_ev <= 1'b1;
    pin_after(3, 1'b1, "cardbus on");
    wake_ev <= 1'b0;
    pin_after(3, 1'b0, "cardbus off");
    cbus <= 1'b0;
    // Mode codes other than auto-load are only stored.
    wrchk(OFF_EE_CMD, 8'hC0, 8'hC0, "other mode code kept");
    wr8(OFF_EE_CMD, 8'h00);
    // Auto-load reloads the LED mode and clears the other bits.
    ee_led <= 2'h1;
    wr8(OFF_WLDC_CFG, 8'hB0);
    wr8(OFF_EE_CMD, 8'h40);
    #1 chk({7'h00, busy}, 8'h01, "load started");
    // A mode write while the load runs is refused.
    wr8(OFF_EE_CMD, 8'h00);
    rchk(OFF_EE_CMD, 8'h40, "mode during load");
    wait_idle();
    chk({6'h00, led}, 8'h01, "led reloaded");
    rchk(OFF_EE_CMD, 8'h00, "back to normal");
    rchk(OFF_WLDC_CFG, 8'h40, "cfg after load");
    rchk(OFF_WPAT_CFG, 8'h00, "pulse sel after load");
    wr8(8'h60, 8'hFF);
    rchk(8'h60, 8'h00, "unmapped");
    end_sim();
  end
endmodule
`default_nettype wire
